/* inc/pwd_defs.svh */
`ifndef PWD_DEFS_SVH
`define PWD_DEFS_SVH
// Overview of operation
// RULE1 - Unserviced enabled watchdog forces full system reset
// RULE2 - Lock line gates protected writes with supervisor
// RULE3 - Error raises NMI first, reset after delay
// RULE4 - 16-bit counter, user or fixed reload
// RULE5 - Input clock is system clock /256 or /16384
// RULE6 - Service access is two consecutive timed writes
// RULE7 - First write carries fixed and user password
// RULE8 - Bad password or bad guard bits start reset
// RULE9 - Counter overflow starts the reset sequence
// RULE10 - Disable stops timeout only, protection stays active
// RULE11 - Second unserviced watchdog reset holds until power-on
// RULE12 - Good access reloads counter, clears time-out state

// Register offsets (byte addresses)
`define PWD_OFF_CTRL   8'h00
`define PWD_OFF_STAT   8'h04
`define PWD_OFF_IRQ    8'h08
`define PWD_OFF_MASK   8'h0C

// Control word fields
`define PWD_F_RLD      31:16
`define PWD_F_UPW      15:8
`define PWD_F_FIX      7:1
`define PWD_F_GUARD    3:2
`define PWD_B_SEL      5
`define PWD_B_DIS      4
`define PWD_B_LOCK     0

// Field values and reset values
`define PWD_FIX_PW     7'h5B
`define PWD_GUARD_OK   2'h2
`define PWD_CNT_FIX    16'hFFFC
`define PWD_CNT_MAX    16'hFFFF
`define PWD_RLD_RST    16'h0000
`define PWD_UPW_RST    8'h00
`define PWD_LOCK_RST   1'b0

// Timing counts in ref_clk cycles
`define PWD_DIV_LO     256
`define PWD_DIV_HI     16384
`define PWD_RST_CYC    8'h10
`endif

/* inc/pwd_pkg.sv */
package pwd_pkg;
	typedef enum logic [2:0] {
		PWD_NORMAL,
		PWD_ACCESS,
		PWD_PREWARN,
		PWD_RESET,
		PWD_HOLD
	} pwd_mode_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pwd_bus_t;

	typedef struct packed {
		logic warn;
		logic ovf;
		logic acc;
	} pwd_evt_t;
endpackage

/* logic/pwd_watchdog.sv */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "pwd_defs.svh"
module pwd_watchdog
#(
	parameter int DIV_LO = `PWD_DIV_LO,
	parameter int DIV_HI = `PWD_DIV_HI
)
(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             ce,
	// Register port
	input  wire pwd_pkg::pwd_bus_t bus,
	output      logic [31:0]      rdata,
	// CPU state
	input  wire logic             cpu_super,
	// System lines
	output      logic             init_done_lock,
	output      logic             prot_wr_en,
	output      logic             nmi,
	output      logic             sys_rst,
	output      logic             irq
);
	localparam int PW = $clog2(DIV_HI);
	localparam int LW = $clog2(DIV_LO);

	generate
		if (DIV_LO < 2 || DIV_LO > DIV_HI || (1 << LW) != DIV_LO || (1 << PW) != DIV_HI)
		begin : g_bad_div
			$error("pwd_watchdog: dividers must be powers of two, DIV_LO <= DIV_HI");
		end
	endgenerate

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	pwd_pkg::pwd_mode_t mode_reg;
	pwd_pkg::pwd_mode_t mode_next;
	logic [15:0]        cnt_reg;
	logic [15:0]        cnt_next;
	logic [PW-1:0]      presc_reg;
	logic [PW-1:0]      presc_next;
	logic [15:0]        rld_reg;
	logic [15:0]        rld_next;
	logic [7:0]         upw_reg;
	logic [7:0]         upw_next;
	logic               dis_reg;
	logic               dis_next;
	logic               sel_reg;
	logic               sel_next;
	logic               lock_reg;
	logic               lock_next;
	logic               prior_reg;
	logic               prior_next;
	logic [7:0]         rcnt_reg;
	logic [7:0]         rcnt_next;
	pwd_pkg::pwd_evt_t  stat_reg;
	pwd_pkg::pwd_evt_t  stat_next;
	pwd_pkg::pwd_evt_t  mask_reg;
	pwd_pkg::pwd_evt_t  mask_next;
	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;
	logic               irq_reg;
	logic               irq_next;
	logic               nmi_reg;
	logic               nmi_next;
	logic               rst_reg;
	logic               rst_next;
	logic               pwe_reg;
	logic               pwe_next;

	logic              tick;
	logic              wr_ctrl;
	logic              err;
	logic              top;
	pwd_pkg::pwd_evt_t evt;
	pwd_pkg::pwd_evt_t w1c;

	// Both dividers share one prescaler, so switching never stretches a period
	assign tick = sel_reg ? (&presc_reg) : (&presc_reg[LW-1:0]); // RULE5
	assign top  = (cnt_reg == `PWD_CNT_MAX);

	always_comb
	begin
		mode_next  = mode_reg;
		cnt_next   = cnt_reg;
		presc_next = presc_reg + {{(PW-1){1'b0}}, 1'b1};
		rld_next   = rld_reg;
		upw_next   = upw_reg;
		dis_next   = dis_reg;
		sel_next   = sel_reg;
		lock_next  = lock_reg;
		prior_next = prior_reg;
		rcnt_next  = rcnt_reg;
		mask_next  = mask_reg;
		rdata_next = rdata_reg;
		evt        = '0;
		w1c        = '0;
		err        = 1'b0;
		wr_ctrl    = bus.wr && hit(bus.addr, `PWD_OFF_CTRL);
		case (mode_reg)
			pwd_pkg::PWD_NORMAL:
			begin
				if (wr_ctrl)
				begin
					// Password checked even when the timeout is disabled
					if (bus.wdata[`PWD_F_FIX] == `PWD_FIX_PW
						&& bus.wdata[`PWD_F_UPW] == upw_reg) // RULE7 RULE10
					begin
						mode_next  = pwd_pkg::PWD_ACCESS; // RULE6
						cnt_next   = `PWD_CNT_FIX; // RULE4
						presc_next = '0;
					end
					else
					begin
						evt.acc = 1'b1;
						err     = 1'b1; // RULE8
					end
				end
				else if (tick && !dis_reg) // RULE10
				begin
					if (top)
					begin
						evt.ovf = 1'b1;
						err     = 1'b1; // RULE9 RULE1
					end
					else
					begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			pwd_pkg::PWD_ACCESS:
			begin
				if (wr_ctrl)
				begin
					if (bus.wdata[`PWD_F_GUARD] == `PWD_GUARD_OK)
					begin
						rld_next   = bus.wdata[`PWD_F_RLD];
						upw_next   = bus.wdata[`PWD_F_UPW];
						sel_next   = bus.wdata[`PWD_B_SEL];
						dis_next   = bus.wdata[`PWD_B_DIS];
						lock_next  = bus.wdata[`PWD_B_LOCK];
						cnt_next   = bus.wdata[`PWD_F_RLD]; // RULE12 RULE4
						presc_next = '0;
						prior_next = 1'b0; // RULE11
						mode_next  = pwd_pkg::PWD_NORMAL; // RULE12
					end
					else
					begin
						evt.acc = 1'b1;
						err     = 1'b1; // RULE8
					end
				end
				else if (tick)
				begin
					// Window between the two writes runs out on overflow
					if (top)
					begin
						evt.ovf = 1'b1;
						err     = 1'b1; // RULE6 RULE9
					end
					else
					begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			pwd_pkg::PWD_PREWARN:
			begin
				if (tick)
				begin
					if (top)
					begin
						rcnt_next = 8'h00;
						mode_next = prior_reg ? pwd_pkg::PWD_HOLD
							: pwd_pkg::PWD_RESET; // RULE3 RULE11
					end
					else
					begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end
			end
			pwd_pkg::PWD_RESET:
			begin
				rcnt_next = rcnt_reg + 8'h01;
				if (rcnt_reg == `PWD_RST_CYC - 8'h01)
				begin
					// Block restarts as after power-on but remembers this reset
					mode_next  = pwd_pkg::PWD_NORMAL;
					cnt_next   = `PWD_RLD_RST;
					presc_next = '0;
					rld_next   = `PWD_RLD_RST;
					upw_next   = `PWD_UPW_RST;
					sel_next   = 1'b0;
					dis_next   = 1'b0;
					lock_next  = `PWD_LOCK_RST;
					mask_next  = '0;
					prior_next = 1'b1; // RULE11
				end
			end
			pwd_pkg::PWD_HOLD:
			begin
				mode_next = pwd_pkg::PWD_HOLD; // RULE11
			end
			default:
			begin
				mode_next = pwd_pkg::PWD_NORMAL;
			end
		endcase

		if (err)
		begin
			mode_next  = pwd_pkg::PWD_PREWARN; // RULE3
			cnt_next   = `PWD_CNT_FIX; // RULE4
			presc_next = '0;
			evt.warn   = 1'b1;
		end

		if (bus.wr && hit(bus.addr, `PWD_OFF_IRQ))
		begin
			w1c = pwd_pkg::pwd_evt_t'(bus.wdata[2:0]);
		end
		if (bus.wr && hit(bus.addr, `PWD_OFF_MASK) && mode_reg != pwd_pkg::PWD_RESET)
		begin
			mask_next = pwd_pkg::pwd_evt_t'(bus.wdata[2:0]);
		end
		// New event beats a same-cycle clear
		stat_next = (stat_reg & ~w1c) | evt;
		// Last reset cycle, so status starts clean like after power-on
		if (mode_reg == pwd_pkg::PWD_RESET && rcnt_reg == `PWD_RST_CYC - 8'h01)
		begin
			stat_next = evt;
		end

		if (bus.rd)
		begin
			if (hit(bus.addr, `PWD_OFF_CTRL))
			begin
				rdata_next = {rld_reg, upw_reg, 2'h0, sel_reg, dis_reg,
					`PWD_GUARD_OK, 1'b0, lock_reg};
			end
			else if (hit(bus.addr, `PWD_OFF_STAT))
			begin
				rdata_next = {cnt_reg, 11'h000, prior_reg, 1'b0, mode_reg};
			end
			else if (hit(bus.addr, `PWD_OFF_IRQ))
			begin
				rdata_next = {29'h00000000, stat_reg};
			end
			else if (hit(bus.addr, `PWD_OFF_MASK))
			begin
				rdata_next = {29'h00000000, mask_reg};
			end
			else
			begin
				rdata_next = 32'h00000000;
			end
		end

		irq_next = |(stat_next & mask_next);
		nmi_next = (mode_next == pwd_pkg::PWD_PREWARN); // RULE3
		rst_next = (mode_next == pwd_pkg::PWD_RESET)
			|| (mode_next == pwd_pkg::PWD_HOLD); // RULE1
		pwe_next = cpu_super && !lock_next; // RULE2
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_reg  <= pwd_pkg::PWD_NORMAL;
			cnt_reg   <= `PWD_RLD_RST;
			presc_reg <= '0;
			rld_reg   <= `PWD_RLD_RST;
			upw_reg   <= `PWD_UPW_RST;
			dis_reg   <= 1'b0;
			sel_reg   <= 1'b0;
			lock_reg  <= `PWD_LOCK_RST;
			prior_reg <= 1'b0;
			rcnt_reg  <= 8'h00;
			stat_reg  <= '0;
			mask_reg  <= '0;
			rdata_reg <= 32'h00000000;
			irq_reg   <= 1'b0;
			nmi_reg   <= 1'b0;
			rst_reg   <= 1'b0;
			pwe_reg   <= 1'b0;
		end
		else if (ce)
		begin
			mode_reg  <= mode_next;
			cnt_reg   <= cnt_next;
			presc_reg <= presc_next;
			rld_reg   <= rld_next;
			upw_reg   <= upw_next;
			dis_reg   <= dis_next;
			sel_reg   <= sel_next;
			lock_reg  <= lock_next;
			prior_reg <= prior_next;
			rcnt_reg  <= rcnt_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
			rdata_reg <= rdata_next;
			irq_reg   <= irq_next;
			nmi_reg   <= nmi_next;
			rst_reg   <= rst_next;
			pwe_reg   <= pwe_next;
		end
	end

	assign rdata          = rdata_reg;
	assign init_done_lock = lock_reg; // RULE2
	assign prot_wr_en     = pwe_reg;
	assign nmi            = nmi_reg;
	assign sys_rst        = rst_reg;
	assign irq            = irq_reg;
endmodule // pwd_watchdog

/* tb/pwd_cpu.sv */
`timescale 1ns/10ps
`include "pwd_defs.svh"
module pwd_cpu
(
	// Clock
	input wire logic              ref_clk,
	// Bus side
	output var pwd_pkg::pwd_bus_t bus,
	input wire logic [31:0]       rdata,
	output var logic              cpu_super
);
	initial
	begin
		bus = '0;
		cpu_super = 1'b1;
	end
	// Strobe dropped at the taking edge, so no access is ever doubled
	task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q);
		@(posedge ref_clk);
		bus <= {a, d, w, !w};
		@(posedge ref_clk);
		bus <= '0;
		#1 q = rdata;
	endtask
	task automatic set_super(input logic s);
		@(posedge ref_clk);
		cpu_super <= s;
	endtask
	task automatic service(input logic [7:0] upw, input logic [31:0] w2);
		logic [31:0] q;
		access(`PWD_OFF_CTRL, {16'h0000, upw, `PWD_FIX_PW, 1'b0}, 1'b1, q);
		access(`PWD_OFF_CTRL, w2, 1'b1, q);
	endtask
endmodule // pwd_cpu

/* tb/pwd_monitor.sv */
`timescale 1ns/10ps
`include "pwd_defs.svh"
module pwd_monitor
(
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              rst_b,
	input wire logic              ce,
	// Bus and CPU state
	input wire pwd_pkg::pwd_bus_t bus,
	input wire logic [31:0]       rdata,
	input wire logic              cpu_super,
	// System lines
	input wire logic              init_done_lock,
	input wire logic              prot_wr_en,
	input wire logic              nmi,
	input wire logic              sys_rst,
	input wire logic              irq
);
	logic [7:0] run_reg;
	logic [7:0] run_next;
	// Saturates so a hold never wraps back to a legal length
	always_comb
		run_next = sys_rst ? run_reg + {7'h00, ce && run_reg != 8'hFF} : 8'h00;
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			run_reg <= 8'h00;
		else
			run_reg <= run_next;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_prot_write_gate: assert property ($past(rst_b, 2) && $past(ce) |->
		prot_wr_en == ($past(cpu_super) && !init_done_lock)) else $error("bad prot_wr_en");
	a_nmi_first: assert property ($rose(sys_rst) |-> $past(nmi))
		else $error("reset without nmi");
	a_nmi_holds: assert property ($rose(nmi) |-> nmi [*8])
		else $error("nmi too short");
	a_rst_no_nmi: assert property (sys_rst |-> !nmi)
		else $error("nmi in reset");
	a_rst_pulse_len: assert property ($fell(sys_rst) |-> run_reg == 8'h10)
		else $error("bad reset length");
	a_hold_stays: assert property (run_reg > 8'h10 |-> sys_rst && !nmi)
		else $error("hold released");
	a_lock_by_write: assert property ($past(rst_b) && $changed(init_done_lock) |->
		$past(bus.wr) || sys_rst || $past(sys_rst)) else $error("lock moved alone");
	a_bad_access: assert property (ce && bus.wr && bus.addr == `PWD_OFF_CTRL && !nmi
		&& !sys_rst && bus.wdata[3:2] != `PWD_GUARD_OK && bus.wdata[7:1] != `PWD_FIX_PW
		|=> nmi) else $error("bad access missed");
endmodule // pwd_monitor
bind pwd_watchdog pwd_monitor i_pwd_monitor (.ref_clk, .rst_b, .ce, .bus, .rdata,
	.cpu_super, .init_done_lock, .prot_wr_en, .nmi, .sys_rst, .irq);

/* tb/tb_top.sv */
`timescale 1ns/10ps
`include "pwd_defs.svh"
module tb_top;
	logic ref_clk, cpu_super, init_done_lock, prot_wr_en, nmi, sys_rst, irq;
	logic              rst_b = 1'b0;
	logic              ce = 1'b1;
	pwd_pkg::pwd_bus_t bus;
	logic [31:0]       rdata;
	logic [31:0]       q;
	int                n_fail = 0;
	int                compares = 0;
	// Supervisor, user field of first write, second write
	logic [40:0]       rows [3] = '{{1'b1, 8'h00, 32'hFFF0_3C09},
		{1'b1, 8'h3C, 32'hFFF0_3C08}, {1'b0, 8'h3C, 32'hFFF0_A528}};
	wire logic [4:0]   lines = {nmi, sys_rst, irq, init_done_lock, prot_wr_en};
	pwd_watchdog #(.DIV_LO(4), .DIV_HI(16)) i_pwd_watchdog (.ref_clk, .rst_b, .ce, .bus,
		.rdata, .cpu_super, .init_done_lock, .prot_wr_en, .nmi, .sys_rst, .irq);
	pwd_cpu i_pwd_cpu (.ref_clk, .bus, .rdata, .cpu_super);
	initial
	begin
		ref_clk = 1'b0;
		forever
			#50 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish;
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		i_pwd_cpu.access(a, 32'h0, 1'b0, q);
		chk("rdata", q & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_pwd_cpu.access(a, d, 1'b1, q);
	endtask
	task automatic wt(input int b, input logic v);
		int k;
		for (k = 0; k < 2000 && lines[b] !== v; k++)
			@(negedge ref_clk);
		if (k == 2000)
		begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`PWD_OFF_CTRL, 32'h8, '1);
		rd(8'h10, 32'h0, '1);
		for (int i = 0; i < 3; i++)
		begin
			i_pwd_cpu.set_super(rows[i][40]);
			i_pwd_cpu.service(rows[i][39:32], rows[i][31:0]);
			rd(`PWD_OFF_CTRL, rows[i][31:0], '1);
			rd(`PWD_OFF_STAT, 32'h0, 32'hFFFF);
			chk("lock", 32'(lines[1:0]), 32'({rows[i][0], rows[i][40] & ~rows[i][0]}));
		end
		// Access window left open until it runs out
		wr(`PWD_OFF_MASK, 32'h7);
		wr(`PWD_OFF_CTRL, 32'h0000_A5B6);
		repeat (60) @(negedge ref_clk);
		chk("nmi", 32'(lines[4]), 32'h0);
		wt(4, 1'b1);
		rd(`PWD_OFF_IRQ, 32'h6, '1);
		chk("irq", 32'(lines[2]), 32'h1);
		wr(`PWD_OFF_IRQ, 32'h2);
		wr(`PWD_OFF_MASK, 32'h3);
		rd(`PWD_OFF_IRQ, 32'h4, '1);
		chk("irq", 32'(lines[2]), 32'h0);
		// Clock enable low freezes the prewarning count
		@(posedge ref_clk);
		ce <= 1'b0;
		repeat (100) @(negedge ref_clk);
		chk("freeze", 32'(lines[4:3]), 32'h2);
		@(posedge ref_clk);
		ce <= 1'b1;
		wt(3, 1'b1);
		wt(3, 1'b0);
		rd(`PWD_OFF_STAT, 32'h10, 32'hFFFF);
		rd(`PWD_OFF_IRQ, 32'h0, '1);
		chk("lines", 32'(lines), 32'h0);
		// Unserviced timer runs over, single reset only
		i_pwd_cpu.set_super(1'b1);
		i_pwd_cpu.service(8'h00, 32'hFFF0_0008);
		rd(`PWD_OFF_STAT, 32'h0, 32'hFFFF);
		// Sixteen ticks of the slow divider would still be counting here
		repeat (70) @(negedge ref_clk);
		chk("nmi", 32'(lines[4]), 32'h1);
		wt(4, 1'b1);
		wt(3, 1'b1);
		wt(3, 1'b0);
		// Disabled timer still checks passwords
		i_pwd_cpu.service(8'h00, 32'hFFF0_0019);
		repeat (300) @(negedge ref_clk);
		chk("lines", 32'(lines[4:1]), 32'h1);
		wr(`PWD_OFF_CTRL, 32'h0000_11B6);
		wt(4, 1'b1);
		wt(3, 1'b1);
		wt(3, 1'b0);
		// Bad guard after a bad-password reset holds until power-on
		wr(`PWD_OFF_CTRL, 32'h0000_00B6);
		wr(`PWD_OFF_CTRL, 32'hFFF0_0001);
		wt(3, 1'b1);
		repeat (100) @(negedge ref_clk);
		chk("hold", 32'(lines[3]), 32'h1);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`PWD_OFF_STAT, 32'h0, 32'hFFFF);
		chk("rst", 32'(lines[3]), 32'h0);
		tally_and_finish;
	end
endmodule // tb_top
